// ---- logic/bcd_pkg.sv ----
// Package: register map, field layout and decode constants for buck config
package bcd_pkg;
  // Register indices; APB byte address is four times the index
  localparam logic [15:0] BCD_IDX_BUCK1  = 16'h7811;
  localparam logic [15:0] BCD_IDX_BUCK2  = 16'h7812;
  localparam logic [15:0] BCD_IDX_STATUS = 16'h7820;
  localparam int          BCD_AW         = 18;
  localparam logic [17:0] BCD_ADDR_BUCK1  = {BCD_IDX_BUCK1, 2'b00};
  localparam logic [17:0] BCD_ADDR_BUCK2  = {BCD_IDX_BUCK2, 2'b00};
  localparam logic [17:0] BCD_ADDR_STATUS = {BCD_IDX_STATUS, 2'b00};
  // Field positions inside a control word
  localparam int BCD_SLOT_HI  = 15;
  localparam int BCD_SLOT_LO  = 13;
  localparam int BCD_RATE_HI  = 9;
  localparam int BCD_RATE_LO  = 8;
  localparam int BCD_PHASE    = 7;
  localparam int BCD_VSEL_HI  = 6;
  localparam int BCD_VSEL_LO  = 2;
  localparam int BCD_CAP_HI   = 1;
  localparam int BCD_CAP_LO   = 0;
  // Values after reset
  localparam logic [15:0] BCD_BUCK1_RST = 16'h0000;
  localparam logic [15:0] BCD_BUCK2_RST = 16'h0080;
  // Switching rate codes; the other two are reserved
  localparam logic [1:0] BCD_RATE_2MHZ = 2'h1;
  localparam logic [1:0] BCD_RATE_4MHZ = 2'h3;
  // Start-up slot codes
  localparam logic [2:0] BCD_SLOT_OFF = 3'h0;
  localparam logic [2:0] BCD_SLOT_HW1 = 3'h6;
  localparam logic [2:0] BCD_SLOT_HW2 = 3'h7;
  // Voltage target in units of 0.1 mV
  localparam logic [14:0] BCD_BASE_DMV = 15'h1770; // 0.6 V
  localparam logic [14:0] BCD_TOP_DMV  = 15'h4650; // 1.8 V
  localparam logic [14:0] BCD_STEP_DMV = 15'h007d; // 12.5 mV
  localparam logic [6:0]  BCD_CODE_MIN = 7'h08;
  localparam logic [6:0]  BCD_CODE_MAX = 7'h68;
  localparam logic [6:0]  BCD_CODE_FAST_MAX = 7'h48; // 1.4 V at 4 MHz
  // Status register bits
  localparam int BCD_ST_B1_RATE_BAD = 0;
  localparam int BCD_ST_B2_RATE_BAD = 1;
  localparam int BCD_ST_B1_OVER     = 2;
  localparam int BCD_ST_B1_RUN      = 3;
  localparam int BCD_ST_B2_RUN      = 4;

  // Drive bundle toward the first converter stage
  typedef struct packed {
    logic        run;
    logic        fast;
    logic        invert;
    logic [1:0]  cap;
    logic [14:0] target;
  } bcd_buck1_t;

  // Drive bundle toward the second converter stage
  typedef struct packed {
    logic run;
    logic fast;
    logic invert;
  } bcd_buck2_t;
endpackage : bcd_pkg

// ---- logic/bcd_top.sv ----
// Buck converter boot configuration decode with APB register access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module bcd_top
  import bcd_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [BCD_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              buck1_enable_in,
  input  wire logic [4:0]        seq_slot_reached,
  input  wire logic              hw_enable1,
  input  wire logic              hw_enable2,
  output bcd_buck1_t             buck1_out,
  output bcd_buck2_t             buck2_out
);

  logic [15:0] b1_reg, b1_next;
  logic [15:0] b2_reg, b2_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  bcd_buck1_t  o1_reg, o1_next;
  bcd_buck2_t  o2_reg, o2_next;
  logic        setup, wr_take;
  logic [15:0] status;

  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & pready_reg & pwrite;

  // Live status word; reserved bits read as zero
  always_comb begin
    status = 16'h0000;
    status[BCD_ST_B1_RATE_BAD] = ~b1_reg[BCD_RATE_LO];
    status[BCD_ST_B2_RATE_BAD] = ~b2_reg[BCD_RATE_LO];
    // Taken from the live word so the flag never lags the rate field
    status[BCD_ST_B1_OVER] =
      (b1_reg[BCD_RATE_HI:BCD_RATE_LO] == BCD_RATE_4MHZ) &&
      ({b1_reg[BCD_VSEL_HI:BCD_VSEL_LO], 2'b00} > BCD_CODE_FAST_MAX);
    status[BCD_ST_B1_RUN] = o1_reg.run;
    status[BCD_ST_B2_RUN] = o2_reg.run;
  end

  // APB slave: answer is prepared in setup, so access has no wait state
  always_comb begin
    b1_next      = b1_reg;
    b2_next      = b2_reg;
    pready_next  = setup;
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (setup) begin
      unique case (paddr)
        BCD_ADDR_BUCK1:  prdata_next = {16'h0000, b1_reg};
        BCD_ADDR_BUCK2:  prdata_next = {16'h0000, b2_reg};
        BCD_ADDR_STATUS: prdata_next = {16'h0000, status};
        default:         pslverr_next = 1'b1;
      endcase
    end
    // Byte lanes let software touch one half of a word alone
    if (wr_take && paddr == BCD_ADDR_BUCK1) begin
      if (pstrb[0]) b1_next[7:0]  = pwdata[7:0];
      if (pstrb[1]) b1_next[15:8] = pwdata[15:8];
    end
    if (wr_take && paddr == BCD_ADDR_BUCK2) begin
      if (pstrb[0]) b2_next[7:0]  = pwdata[7:0];
      if (pstrb[1]) b2_next[15:8] = pwdata[15:8];
    end
  end

  // Register file and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b1_reg      <= BCD_BUCK1_RST;
      b2_reg      <= BCD_BUCK2_RST;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      b1_reg      <= b1_next;
      b2_reg      <= b2_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Decode toward the power stages
  logic [2:0] slot;
  logic [6:0] code, clamped;
  always_comb begin
    code    = {b1_reg[BCD_VSEL_HI:BCD_VSEL_LO], 2'b00};
    clamped = code;
    if (code < BCD_CODE_MIN) clamped = BCD_CODE_MIN;
    if (code > BCD_CODE_MAX) clamped = BCD_CODE_MAX;
    o1_next.target = BCD_BASE_DMV + 15'(BCD_STEP_DMV *
                     15'(clamped - BCD_CODE_MIN));
    o1_next.fast   = b1_reg[BCD_RATE_HI:BCD_RATE_LO] == BCD_RATE_4MHZ;
    o1_next.invert = b1_reg[BCD_PHASE];
    o1_next.cap    = b1_reg[BCD_CAP_HI:BCD_CAP_LO];
    // A reserved rate would set an undefined switching clock, so hold off
    o1_next.run    = buck1_enable_in & b1_reg[BCD_RATE_LO];
    slot = b2_reg[BCD_SLOT_HI:BCD_SLOT_LO];
    unique case (slot)
      BCD_SLOT_OFF: o2_next.run = 1'b0;
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
        o2_next.run = seq_slot_reached[3'(slot - 3'h1)];
      BCD_SLOT_HW1: o2_next.run = hw_enable1;
      BCD_SLOT_HW2: o2_next.run = hw_enable2;
    endcase
    o2_next.run    = o2_next.run & b2_reg[BCD_RATE_LO];
    o2_next.fast   = b2_reg[BCD_RATE_HI:BCD_RATE_LO] == BCD_RATE_4MHZ;
    o2_next.invert = b2_reg[BCD_PHASE];
  end

  // Outputs to the stages are registered to keep them glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset drive equals the decode of the reset words, so the stages
      // see no step at the first edge after release
      o1_reg <= '{run: 1'b0, fast: 1'b0, invert: BCD_BUCK1_RST[BCD_PHASE],
                  cap: 2'b00, target: BCD_BASE_DMV};
      o2_reg <= '{run: 1'b0, fast: 1'b0, invert: BCD_BUCK2_RST[BCD_PHASE]};
    end else begin
      o1_reg <= o1_next;
      o2_reg <= o2_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign buck1_out = o1_reg;
  assign buck2_out = o2_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // First stage voltage, phase and rate checks, plus second stage phase, slot and enable checks and the APB answer check
  a_b1_target_floor: assert property (
    (b1_reg[6:2] <= 5'd2) |=> (buck1_out.target == BCD_BASE_DMV))
    else $error("buck1 target not held at floor");
  a_b1_target_ceil: assert property (
    (b1_reg[6:2] >= 5'd26) |=> (buck1_out.target == BCD_TOP_DMV))
    else $error("buck1 target not held at ceiling");
  a_b1_target_step: assert property (
    (b1_reg[6:2] > 5'd2 && b1_reg[6:2] < 5'd26) |=>
    (int'(buck1_out.target) == 6000 + 500 * (int'($past(b1_reg[6:2])) - 2)))
    else $error("buck1 target step not 50mV per field step");
  a_b1_phase_follow: assert property (
    $changed(b1_reg[7]) |=> (buck1_out.invert == $past(b1_reg[7]))
    ##1 $stable(buck1_out.invert))
    else $error("buck1 phase not following control bit");
  a_b2_phase_clear: assert property (
    (wr_take && paddr == BCD_ADDR_BUCK2 && pstrb[0] && !pwdata[7])
    |=> !b2_reg[7] ##1 !buck2_out.invert)
    else $error("buck2 phase write of zero not applied");
  a_b2_slot_off: assert property (
    (b2_reg[15:13] == 3'h0) |=> !buck2_out.run)
    else $error("buck2 runs with slot disabled");
  a_b2_slot_seq: assert property (
    (b2_reg[15:13] == 3'h3 && b2_reg[8]) |=>
    (buck2_out.run == $past(seq_slot_reached[2])))
    else $error("buck2 not started in its timeslot");
  a_b2_hw_enable: assert property (
    (b2_reg[15:13] == 3'h7 && b2_reg[8]) |=>
    (buck2_out.run == $past(hw_enable2)))
    else $error("buck2 not following hardware enable two");
  a_bad_rate_halt: assert property (
    !b1_reg[8] |-> status[BCD_ST_B1_RATE_BAD] ##1 !buck1_out.run)
    else $error("buck1 switching with reserved rate");
  a_apb_answer: assert property (
    setup |=> pready ##1 !pready || (psel && !penable))
    else $error("APB answer not one cycle after setup");
  a_b1_run_gate: assert property (
    (b1_reg[8] && buck1_enable_in) |=> buck1_out.run)
    else $error("buck1 not running with valid rate and enable");
  a_b1_rate_fast: assert property (
    (b1_reg[9:8] == 2'h3) |=> buck1_out.fast)
    else $error("buck1 fast rate not decoded");
  a_b1_over_flag: assert property (
    (b1_reg[9:8] == 2'h3 && b1_reg[6:2] > 5'd18) |-> status[BCD_ST_B1_OVER])
    else $error("buck1 code above limit at fast rate not flagged");
  // Second stage phase, slot, enable and rate decode
  a_b2_phase_follow: assert property (
    $changed(b2_reg[7]) |=> (buck2_out.invert == $past(b2_reg[7])))
    else $error("buck2 phase not following control bit");
  a_b2_slot_any: assert property (
    (b2_reg[15:13] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5} && b2_reg[8]) |=>
    (buck2_out.run == $past(seq_slot_reached[3'(b2_reg[15:13] - 3'h1)])))
    else $error("buck2 not started in its selected timeslot");
  a_b2_hw1_enable: assert property (
    (b2_reg[15:13] == 3'h6 && b2_reg[8]) |=>
    (buck2_out.run == $past(hw_enable1)))
    else $error("buck2 not following hardware enable one");
  a_b2_rate_block: assert property (
    !b2_reg[8] |=> !buck2_out.run)
    else $error("buck2 switching with reserved rate");

  c_b1_write: cover property (wr_take && paddr == BCD_ADDR_BUCK1);
  c_b1_fast_run: cover property (buck1_out.run && buck1_out.fast);
  c_b2_hw1_run: cover property (b2_reg[15:13] == 3'h6 && buck2_out.run);
  c_b1_over: cover property (status[BCD_ST_B1_OVER]);
  c_b2_slot_run: cover property (b2_reg[15:13] == 3'h2 && buck2_out.run);
endmodule : bcd_top

// ---- tb/bcd_stage_model.sv ----
// Converter power stage model driven by the decode outputs
`timescale 1ns/1ps
module bcd_stage_model
  import bcd_pkg::*;
(
  input  wire logic       pclk,
  input  wire bcd_buck1_t buck1_drive,
  input  wire bcd_buck2_t buck2_drive,
  output logic     [14:0] vout_dmv,
  output logic            buck2_switching
);
  // Regulates only while run holds, else the output sags to zero
  always_ff @(posedge pclk) begin
    vout_dmv        <= buck1_drive.run ? buck1_drive.target : 15'h0000;
    buck2_switching <= buck2_drive.run;
  end
endmodule : bcd_stage_model

// ---- tb/tb_buck_converter_otp_config_decode.sv ----
// Self-checking bench for the buck boot configuration decode
`timescale 1ns/1ps
module tb_buck_converter_otp_config_decode;
  import bcd_pkg::*;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic              pwrite = 0, pready, pslverr, err, b1_en = 0;
  logic              hw1 = 0, hw2 = 0, sw2;
  logic [BCD_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd, w, seed = 32'h7a4f;
  logic [3:0]        pstrb = 4'hf;
  logic [4:0]        slots = '0, f;
  logic [4:0]        cf [6] = '{5'h00, 5'h02, 5'h03, 5'h19, 5'h1a, 5'h1f};
  logic [1:0]        r;
  logic              en;
  logic [14:0]       vout;
  bcd_buck1_t        b1;
  bcd_buck2_t        b2;
  int                fail_count = 0, checked = 0;

  always #10 pclk = ~pclk;

  bcd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .buck1_enable_in(b1_en), .seq_slot_reached(slots), .hw_enable1(hw1),
    .hw_enable2(hw2), .buck1_out(b1), .buck2_out(b2));
  bcd_stage_model stage (.pclk(pclk), .buck1_drive(b1), .buck2_drive(b2),
    .vout_dmv(vout), .buck2_switching(sw2));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Target in 0.1 mV, saturating below code 08h and from code 68h
  function automatic logic [14:0] tgt(input logic [4:0] fld);
    logic [6:0] c;
    c = {fld, 2'b00};
    if (c <= BCD_CODE_MIN) return BCD_BASE_DMV;
    if (c >= BCD_CODE_MAX) return BCD_TOP_DMV;
    return BCD_BASE_DMV + 15'((c - BCD_CODE_MIN) * BCD_STEP_DMV);
  endfunction : tgt

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the edge where pready is seen high, then released
    do begin
      @(posedge pclk);
      if (++n > 20) begin
        fail_count++;
        end_of_test;
      end
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, BCD_ADDR_BUCK1, 0);
    chk("buck1 word", 32'h0, rd);
    apb(0, BCD_ADDR_BUCK2, 0);
    chk("buck2 word", 32'h80, rd);
    chk("buck2 invert", 1, b2.invert);
    apb(0, 18'h00100, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    // Buck1: corner voltage fields first, every rate code in turn
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      f = (i < 6) ? cf[i] : seed[6:2];
      r = i[1:0];
      w = {16'h0, seed[15:10], r, seed[7], f, seed[1:0]};
      @(posedge pclk);
      b1_en <= seed[20];
      apb(1, BCD_ADDR_BUCK1, w);
      repeat (3) @(posedge pclk);
      #1;
      chk("target", tgt(f), b1.target);
      chk("invert", seed[7], b1.invert);
      chk("cap", seed[1:0], b1.cap);
      chk("run1", r[0] & b1_en, b1.run);
      chk("fast", r == 2'h3, b1.fast);
      chk("vout", (r[0] & b1_en) ? tgt(f) : 15'h0, vout);
      apb(0, BCD_ADDR_STATUS, 0);
      // Second stage still holds its reset word: reserved rate, slot off
      chk("status", {1'b0, r[0] & b1_en, r == 2'h3 &&
          {f, 2'b0} > BCD_CODE_FAST_MAX, 1'b1, ~r[0]}, rd[4:0]);
    end
    // Buck2: every slot code, then random rates and phases
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      r = (i < 8) ? BCD_RATE_2MHZ : seed[9:8];
      w = {16'h0, i[2:0], 3'h0, r, seed[7], 7'h0};
      @(posedge pclk);
      slots <= seed[4:0];
      hw1   <= seed[5];
      hw2   <= seed[6];
      apb(1, BCD_ADDR_BUCK2, w);
      repeat (3) @(posedge pclk);
      #1;
      case (i[2:0])
        3'h0:    en = 1'b0;
        3'h6:    en = hw1;
        3'h7:    en = hw2;
        default: en = slots[i[2:0] - 3'h1];
      endcase
      chk("run2", en & r[0], b2.run);
      chk("invert2", seed[7], b2.invert);
      chk("fast2", r == 2'h3, b2.fast);
      chk("switch2", en & r[0], sw2);
      apb(0, BCD_ADDR_STATUS, 0);
      chk("status2", {en & r[0], ~r[0]}, {rd[4], rd[1]});
    end
    // Low byte lane alone clears the phase and keeps slot and rate
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1, BCD_ADDR_BUCK2, 32'h0000_ff00);
    apb(0, BCD_ADDR_BUCK2, 0);
    chk("byte lane", {16'h0, w[15:8], 8'h00}, rd);
    chk("invert2 clear", 0, b2.invert);
    // Mid-run reset restores both words and the phase outputs
    @(posedge pclk);
    pstrb   <= 4'hf;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, BCD_ADDR_BUCK1, 0);
    chk("buck1 word rst", 32'h0, rd);
    chk("invert rst", 0, b1.invert);
    apb(0, BCD_ADDR_BUCK2, 0);
    chk("buck2 word rst", 32'h80, rd);
    chk("invert2 rst", 1, b2.invert);
    end_of_test;
  end
endmodule : tb_buck_converter_otp_config_decode
